// ===== hdl/rcs_defs.svh
// Constants of the reset and configuration sequencer.
// Included by the sequencer and its port monitor; definitions only.
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

`define RCS_GPIO_W        8
`define RCS_SEL_LSB       0
`define RCS_SEL_W         4
`define RCS_STRAP_EEP_EN  4
`define RCS_STRAP_I2C     5
`define RCS_STATE_W       16

// EEPROM search ranges
`define RCS_EEP_BASE      7'h50
`define RCS_EEP_IDX_LAST  3'h7
`define RCS_EEP_OFF_LO    16'h0000
`define RCS_EEP_OFF_HI    16'hf000
`define RCS_SPD_1M        2'h0
`define RCS_SPD_400K      2'h1
`define RCS_SPD_100K      2'h2

// EEPROM operation kinds
`define RCS_OP_PROBE      2'h0
`define RCS_OP_UPDATE     2'h1
`define RCS_OP_CONFIG     2'h2

`endif

// ===== hdl/rcs_pkg.sv
// Types of the reset and configuration sequencer.
// Needs nothing else; included before the modules.
package rcs_pkg;

    typedef enum logic [15:0] {
        RCS_ST_INFO   = 16'h0001,
        RCS_ST_PLL    = 16'h0002,
        RCS_ST_ARMED  = 16'h0004,
        RCS_ST_IMAGE  = 16'h0008,
        RCS_ST_PROBE  = 16'h0010,
        RCS_ST_UPD    = 16'h0020,
        RCS_ST_UPDAPP = 16'h0040,
        RCS_ST_OTPCFG = 16'h0080,
        RCS_ST_EEPCFG = 16'h0100,
        RCS_ST_HOTFIX = 16'h0200,
        RCS_ST_RELOCK = 16'h0400,
        RCS_ST_SERIAL = 16'h0800,
        RCS_ST_APPLY  = 16'h1000,
        RCS_ST_MON    = 16'h2000,
        RCS_ST_ALARM  = 16'h4000,
        RCS_ST_DONE   = 16'h8000
    } rcs_state_t;

    typedef struct packed {
        rcs_state_t  st;
        logic [7:0]  strap;
        logic        mr_prev;
        logic        restart;
        logic [2:0]  idx;
        logic [2:0]  first;
        logic [1:0]  spd;
        logic        offs_hi;
        logic        eep_present;
        logic        cfg_loaded;
        logic [3:0]  cfg_num;
        logic        ser_i2c;
        logic        bg_cal;
        logic        err_otp_missing;
        logic        err_otp_crc;
        logic        err_no_eep;
        logic        err_eep_cfg;
        logic        ser_en;
        logic        outs_en;
        logic        mon_en;
        logic        alarm_en;
    } rcs_regs_t;

endpackage

// ===== hdl/rcs_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes one clock; pins are asynchronous to it.
`timescale 1ns/1ns
module rcs_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// ===== hdl/rcs_sequencer.sv
// Power-up and reset boot sequencer of a multi-channel timing device.
// Assumes same-clock engines for OTP, EEPROM, PLL and image work,
// each answering a held request with a one-cycle done pulse.
// Functional notes
// - Sequence starts at master reset rising edge, only with test high.
// - In reset: clock outputs off, GPIO undriven, serial port silent.
// - Load device info, then calibrate and lock system PLL first.
// - GPIO straps captured at master reset rise, steer later steps.
// - Build default register image without touching pins or outputs.
// - Strap selects serial protocol; SPI defaults to 4-wire form.
// - If enabled, find EEPROM update, apply it, restart sequence.
// - Load strap-selected OTP config; report errors or loaded number.
// - OTP config writes only listed registers; rest stay default.
// - After OTP load: background PLL cal if divider set; reset protocol.
// - EEPROM config search skips bad blocks until one applied or done.
// - Run OTP hotfix after both configuration steps.
// - Finish: relock if a config loaded, serial, apply image, monitors, then alarms.
// - Complete with defaults on failure; expose failure status bits.
// - Probe EEPROMs 1010000..1010111 at 1 MHz, 400 kHz, 100 kHz.
// - Skip all EEPROM searches when strapped to SPI.
// - Config blocks checked only at offsets 0x0000 and 0xF000.
`timescale 1ns/1ns
`include "rcs_defs.svh"
module rcs_sequencer (
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   master_reset_n_in,
    input  wire logic                   test_mode_n_in,
    input  wire logic [`RCS_GPIO_W-1:0] gpio_in,
    output logic                        info_req_out,
    input  wire logic                   info_done_in,
    output logic                        pll_cal_req_out,
    input  wire logic                   pll_lock_in,
    output logic                        pll_bg_cal_out,
    output logic                        image_init_req_out,
    input  wire logic                   image_done_in,
    output logic                        eep_req_out,
    output logic [1:0]                  eep_kind_out,
    output logic [6:0]                  eep_dev_addr_out,
    output logic [1:0]                  eep_speed_out,
    output logic [15:0]                 eep_offset_out,
    input  wire logic                   eep_done_in,
    input  wire logic                   eep_ack_in,
    input  wire logic                   eep_valid_in,
    output logic                        upd_apply_req_out,
    input  wire logic                   upd_apply_done_in,
    output logic                        otp_cfg_req_out,
    output logic [3:0]                  otp_cfg_num_out,
    input  wire logic                   otp_cfg_done_in,
    input  wire logic                   otp_cfg_found_in,
    input  wire logic                   otp_cfg_crc_ok_in,
    input  wire logic                   otp_fbdiv_set_in,
    input  wire logic                   otp_ser_i2c_in,
    input  wire logic                   hotfix_present_in,
    output logic                        hotfix_req_out,
    input  wire logic                   hotfix_done_in,
    output logic                        image_apply_req_out,
    input  wire logic                   image_apply_done_in,
    output logic                        serial_en_out,
    output logic                        serial_i2c_out,
    output logic                        spi_4wire_out,
    output logic                        clk_out_en_out,
    output logic                        gpio_oe_n_out,
    output logic                        monitors_en_out,
    output logic                        alarms_en_out,
    output logic                        seq_done_out,
    output logic                        cfg_loaded_out,
    output logic [3:0]                  cfg_num_out,
    output logic                        err_otp_missing_out,
    output logic                        err_otp_crc_out,
    output logic                        err_no_eeprom_out,
    output logic                        err_eep_cfg_out
);
    logic [`RCS_GPIO_W+1:0] pins_s;
    logic                   mr_s;
    logic                   test_s;
    logic [`RCS_GPIO_W-1:0] gpio_s;
    logic                   mr_rise;
    logic                   eep_ok;
    rcs_pkg::rcs_regs_t     s_r;
    rcs_pkg::rcs_regs_t     s_nxt;

    // Pins and straps share one synchroniser so they stay aligned
    rcs_sync #(
        .W (`RCS_GPIO_W + 2)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({master_reset_n_in, test_mode_n_in, gpio_in}),
        .sync_out   (pins_s)
    );

    assign mr_s   = pins_s[`RCS_GPIO_W+1];
    assign test_s = pins_s[`RCS_GPIO_W];
    assign gpio_s = pins_s[`RCS_GPIO_W-1:0];
    assign mr_rise = mr_s & ~s_r.mr_prev & test_s;
    // EEPROM enabled by strap and reachable only in I2C mode
    assign eep_ok = s_r.strap[`RCS_STRAP_EEP_EN]
                  & s_r.strap[`RCS_STRAP_I2C];

    // Sequencing of the whole boot flow
    always_comb begin
        s_nxt = s_r;
        s_nxt.mr_prev = mr_s;
        case (s_r.st)
            rcs_pkg::RCS_ST_INFO: begin
                if (info_done_in) begin
                    s_nxt.st = rcs_pkg::RCS_ST_PLL;
                end
            end
            rcs_pkg::RCS_ST_PLL: begin
                if (pll_lock_in) begin
                    s_nxt.st = s_r.restart ? rcs_pkg::RCS_ST_IMAGE
                                           : rcs_pkg::RCS_ST_ARMED;
                end
            end
            rcs_pkg::RCS_ST_ARMED: begin
                if (mr_rise) begin
                    s_nxt.strap = gpio_s;
                    s_nxt.st    = rcs_pkg::RCS_ST_IMAGE;
                end
            end
            rcs_pkg::RCS_ST_IMAGE: begin
                // Protocol follows strap; pins untouched meanwhile
                s_nxt.ser_i2c = s_r.strap[`RCS_STRAP_I2C];
                if (image_done_in) begin
                    s_nxt.idx = 3'h0;
                    s_nxt.spd = `RCS_SPD_1M;
                    s_nxt.st  = eep_ok ? rcs_pkg::RCS_ST_PROBE
                                       : rcs_pkg::RCS_ST_OTPCFG;
                end
            end
            rcs_pkg::RCS_ST_PROBE: begin
                if (eep_done_in) begin
                    if (eep_ack_in) begin
                        s_nxt.eep_present = 1'b1;
                        s_nxt.first       = s_r.idx;
                        s_nxt.offs_hi     = 1'b0;
                        s_nxt.st          = rcs_pkg::RCS_ST_UPD;
                    end else if (s_r.idx != `RCS_EEP_IDX_LAST) begin
                        s_nxt.idx = s_r.idx + 3'h1;
                    end else if (s_r.spd != `RCS_SPD_100K) begin
                        s_nxt.idx = 3'h0;
                        s_nxt.spd = s_r.spd + 2'h1;
                    end else begin
                        s_nxt.err_no_eep = 1'b1;
                        s_nxt.st         = rcs_pkg::RCS_ST_OTPCFG;
                    end
                end
            end
            rcs_pkg::RCS_ST_UPD: begin
                if (eep_done_in) begin
                    if (eep_valid_in) begin
                        s_nxt.st = rcs_pkg::RCS_ST_UPDAPP;
                    end else if (s_r.idx != `RCS_EEP_IDX_LAST) begin
                        s_nxt.idx = s_r.idx + 3'h1;
                    end else begin
                        s_nxt.st = rcs_pkg::RCS_ST_OTPCFG;
                    end
                end
            end
            rcs_pkg::RCS_ST_UPDAPP: begin
                // Restart from the starting condition, straps kept
                if (upd_apply_done_in) begin
                    s_nxt.restart     = 1'b1;
                    s_nxt.eep_present = 1'b0;
                    s_nxt.st          = rcs_pkg::RCS_ST_INFO;
                end
            end
            rcs_pkg::RCS_ST_OTPCFG: begin
                if (otp_cfg_done_in) begin
                    if (!otp_cfg_found_in) begin
                        s_nxt.err_otp_missing = 1'b1;
                    end else if (!otp_cfg_crc_ok_in) begin
                        s_nxt.err_otp_crc = 1'b1;
                    end else begin
                        s_nxt.cfg_loaded = 1'b1;
                        s_nxt.cfg_num    = otp_cfg_num_out;
                        s_nxt.bg_cal     = otp_fbdiv_set_in;
                        s_nxt.ser_i2c    = otp_ser_i2c_in;
                    end
                    s_nxt.idx     = s_r.first;
                    s_nxt.offs_hi = 1'b0;
                    s_nxt.st      = s_r.eep_present
                                  ? rcs_pkg::RCS_ST_EEPCFG
                                  : rcs_pkg::RCS_ST_HOTFIX;
                end
            end
            rcs_pkg::RCS_ST_EEPCFG: begin
                if (eep_done_in) begin
                    if (eep_valid_in) begin
                        s_nxt.cfg_loaded = 1'b1;
                        s_nxt.st         = rcs_pkg::RCS_ST_HOTFIX;
                    end else if (!s_r.offs_hi) begin
                        s_nxt.offs_hi = 1'b1;
                    end else if (s_r.idx != `RCS_EEP_IDX_LAST) begin
                        s_nxt.offs_hi = 1'b0;
                        s_nxt.idx     = s_r.idx + 3'h1;
                    end else begin
                        s_nxt.err_eep_cfg = 1'b1;
                        s_nxt.st          = rcs_pkg::RCS_ST_HOTFIX;
                    end
                end
            end
            rcs_pkg::RCS_ST_HOTFIX: begin
                if (!hotfix_present_in || hotfix_done_in) begin
                    s_nxt.st = s_r.cfg_loaded ? rcs_pkg::RCS_ST_RELOCK
                                              : rcs_pkg::RCS_ST_SERIAL;
                end
            end
            rcs_pkg::RCS_ST_RELOCK: begin
                if (pll_lock_in) begin
                    s_nxt.bg_cal = 1'b0;
                    s_nxt.st     = rcs_pkg::RCS_ST_SERIAL;
                end
            end
            rcs_pkg::RCS_ST_SERIAL: begin
                s_nxt.ser_en = 1'b1;
                s_nxt.st     = rcs_pkg::RCS_ST_APPLY;
            end
            rcs_pkg::RCS_ST_APPLY: begin
                if (image_apply_done_in) begin
                    s_nxt.outs_en = 1'b1;
                    s_nxt.st      = rcs_pkg::RCS_ST_MON;
                end
            end
            rcs_pkg::RCS_ST_MON: begin
                s_nxt.mon_en = 1'b1;
                s_nxt.st     = rcs_pkg::RCS_ST_ALARM;
            end
            rcs_pkg::RCS_ST_ALARM: begin
                s_nxt.alarm_en = 1'b1;
                s_nxt.st       = rcs_pkg::RCS_ST_DONE;
            end
            default: begin
                s_nxt.st = rcs_pkg::RCS_ST_DONE;
            end
        endcase
        // Pin reset low returns to the quiet starting condition, but
        // info load and PLL lock still advance so the rise is not missed
        if (!mr_s) begin
            s_nxt.st = (s_nxt.st == rcs_pkg::RCS_ST_PLL ||
                        s_nxt.st == rcs_pkg::RCS_ST_ARMED)
                     ? s_nxt.st : rcs_pkg::RCS_ST_INFO;
            s_nxt    = '{st: s_nxt.st, default: '0};
        end
    end

    // State register; reset value parks in the starting condition
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_r    <= '0;
            s_r.st <= rcs_pkg::RCS_ST_INFO;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Requests held for the whole step
    assign info_req_out        = s_r.st == rcs_pkg::RCS_ST_INFO;
    assign pll_cal_req_out     = s_r.st == rcs_pkg::RCS_ST_PLL
                               || s_r.st == rcs_pkg::RCS_ST_RELOCK;
    assign image_init_req_out  = s_r.st == rcs_pkg::RCS_ST_IMAGE;
    assign upd_apply_req_out   = s_r.st == rcs_pkg::RCS_ST_UPDAPP;
    assign otp_cfg_req_out     = s_r.st == rcs_pkg::RCS_ST_OTPCFG;
    assign hotfix_req_out      = s_r.st == rcs_pkg::RCS_ST_HOTFIX
                               && hotfix_present_in;
    assign image_apply_req_out = s_r.st == rcs_pkg::RCS_ST_APPLY;
    assign eep_req_out         = s_r.st == rcs_pkg::RCS_ST_PROBE
                               || s_r.st == rcs_pkg::RCS_ST_UPD
                               || s_r.st == rcs_pkg::RCS_ST_EEPCFG;
    assign eep_kind_out = (s_r.st == rcs_pkg::RCS_ST_UPD) ? `RCS_OP_UPDATE
                        : (s_r.st == rcs_pkg::RCS_ST_EEPCFG)
                        ? `RCS_OP_CONFIG : `RCS_OP_PROBE;
    assign eep_dev_addr_out = `RCS_EEP_BASE | {4'h0, s_r.idx};
    assign eep_speed_out    = s_r.spd;
    assign eep_offset_out   = s_r.offs_hi ? `RCS_EEP_OFF_HI
                                          : `RCS_EEP_OFF_LO;
    assign otp_cfg_num_out  =
        s_r.strap[`RCS_SEL_LSB +: `RCS_SEL_W];

    // Register-driven status and enables
    assign pll_bg_cal_out      = s_r.bg_cal;
    assign serial_en_out       = s_r.ser_en;
    assign serial_i2c_out      = s_r.ser_i2c;
    assign spi_4wire_out       = ~s_r.ser_i2c;
    assign clk_out_en_out      = s_r.outs_en;
    assign gpio_oe_n_out       = ~s_r.outs_en;
    assign monitors_en_out     = s_r.mon_en;
    assign alarms_en_out       = s_r.alarm_en;
    assign seq_done_out        = s_r.st == rcs_pkg::RCS_ST_DONE;
    assign cfg_loaded_out      = s_r.cfg_loaded;
    assign cfg_num_out         = s_r.cfg_num;
    assign err_otp_missing_out = s_r.err_otp_missing;
    assign err_otp_crc_out     = s_r.err_otp_crc;
    assign err_no_eeprom_out   = s_r.err_no_eep;
    assign err_eep_cfg_out     = s_r.err_eep_cfg;
endmodule

// ===== tb/rcs_seq_monitor.sv
// Port checker of the reset and configuration sequencer.
// Bound into the sequencer by the bench; sees only its ports.
`timescale 1ns/1ns
`include "rcs_defs.svh"
module rcs_seq_monitor (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic        master_reset_n_in,
    input wire logic        image_init_req_out,
    input wire logic        eep_req_out,
    input wire logic [1:0]  eep_kind_out,
    input wire logic [6:0]  eep_dev_addr_out,
    input wire logic [1:0]  eep_speed_out,
    input wire logic [15:0] eep_offset_out,
    input wire logic        eep_done_in,
    input wire logic        eep_ack_in,
    input wire logic        otp_cfg_req_out,
    input wire logic [3:0]  otp_cfg_num_out,
    input wire logic        otp_cfg_done_in,
    input wire logic        otp_cfg_found_in,
    input wire logic        hotfix_req_out,
    input wire logic        image_apply_req_out,
    input wire logic        serial_en_out,
    input wire logic        clk_out_en_out,
    input wire logic        gpio_oe_n_out,
    input wire logic        monitors_en_out,
    input wire logic        alarms_en_out,
    input wire logic        seq_done_out,
    input wire logic        cfg_loaded_out,
    input wire logic [3:0]  cfg_num_out,
    input wire logic        err_otp_missing_out,
    input wire logic        err_no_eeprom_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Tail of the finish walk, one step per cycle
    sequence tail_s;
        $rose(monitors_en_out) ##1 $rose(alarms_en_out) ##1 seq_done_out;
    endsequence

    // Pin passes two sync stages, so six low cycles before judging
    quiet_in_reset_a: assert property (
        !master_reset_n_in [*6] |-> !clk_out_en_out && gpio_oe_n_out
            && !serial_en_out && !alarms_en_out)
        else $error("outputs live during master reset");
    image_quiet_a: assert property (
        image_init_req_out |-> !clk_out_en_out && gpio_oe_n_out)
        else $error("outputs changed while image built");
    cfg_num_a: assert property (
        $rose(cfg_loaded_out) && $past(otp_cfg_req_out)
            |-> cfg_num_out == $past(otp_cfg_num_out))
        else $error("loaded config number wrong");
    otp_missing_a: assert property (
        otp_cfg_req_out && otp_cfg_done_in && !otp_cfg_found_in
            |=> err_otp_missing_out && !otp_cfg_req_out)
        else $error("missing config not reported");
    eep_where_a: assert property (
        eep_req_out |-> eep_dev_addr_out[6:3] == 4'ha
            && (eep_offset_out == 16'h0000 || eep_offset_out == 16'hf000))
        else $error("EEPROM address or offset out of range");
    no_eeprom_a: assert property (
        eep_req_out && eep_kind_out == `RCS_OP_PROBE && eep_done_in
            && !eep_ack_in && eep_dev_addr_out == 7'h57
            && eep_speed_out == `RCS_SPD_100K
            |=> err_no_eeprom_out && !eep_req_out)
        else $error("empty probe not reported");
    hotfix_order_a: assert property (
        $rose(hotfix_req_out) |-> $past(otp_cfg_req_out) || $past(eep_req_out))
        else $error("hotfix before configuration");
    apply_order_a: assert property (
        $rose(image_apply_req_out) |-> serial_en_out)
        else $error("image applied before serial enable");
    finish_order_a: assert property (
        $rose(clk_out_en_out) |-> !gpio_oe_n_out ##1 tail_s)
        else $error("finish steps out of order");
endmodule

// ===== tb/rcs_engine_model.sv
// Far-side engines of the sequencer: OTP, EEPROM, PLL, image, hotfix.
// Assumes one clock; answers each held request with a done pulse.
`timescale 1ns/1ns
module rcs_engine_model (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  req_in,
    input  wire logic [1:0]  kind_in,
    input  wire logic [6:0]  addr_in,
    input  wire logic [1:0]  speed_in,
    input  wire logic [15:0] offset_in,
    input  wire logic        slow_in,
    input  wire logic        fit_in,
    input  wire logic        upd_in,
    input  wire logic        cfg_in,
    output logic      [7:0]  done_out,
    output logic             ack_out,
    output logic             valid_out
);
    logic [7:0] done_r;
    logic [1:0] cnt_r;
    logic       ack_r;
    logic       val_r;
    logic       tog_r;
    logic       used_r;
    logic       hit;

    // One EEPROM at index 2, too slow for the 1 MHz probe
    assign hit = fit_in && addr_in == 7'h52 && speed_in != 2'h0;
    assign done_out = done_r;
    // Outside a done pulse the flags toggle, so stale use shows
    assign ack_out = done_r[3] ? ack_r : tog_r;
    assign valid_out = done_r[3] ? val_r : ~tog_r;

    // One request at a time, answered promptly or after four cycles
    always_ff @(posedge sys_clk_in) begin
        tog_r <= rst_n_in & ~tog_r;
        if (!rst_n_in) begin
            done_r <= 8'h00;
            cnt_r  <= 2'h0;
            used_r <= 1'b0;
        end else if (done_r != 8'h00 || req_in == 8'h00) begin
            done_r <= 8'h00;
            cnt_r  <= 2'h0;
        end else if (slow_in && cnt_r != 2'h3) begin
            cnt_r <= cnt_r + 2'h1;
        end else begin
            done_r <= req_in;
            ack_r  <= hit;
            // Update offered once; one full config block
            val_r  <= hit && (kind_in == 2'h1 ? upd_in && !used_r
                      : kind_in == 2'h2 && cfg_in && offset_in == 16'hf000);
            used_r <= used_r | req_in[4];
        end
    end
endmodule

// ===== tb/rcs_sequencer_test.sv
// Bench of the reset and configuration sequencer.
// Drives pins and knobs; engines come from the partner model.
`timescale 1ns/1ns
module rcs_sequencer_test;
    logic        sys_clk_in, rst_n_in, master_reset_n_in, test_mode_n_in;
    logic [7:0]  gpio_in, done;
    logic        info_req_out, info_done_in, pll_cal_req_out, pll_lock_in;
    logic        pll_bg_cal_out, image_init_req_out, image_done_in;
    logic        eep_req_out, eep_done_in, eep_ack_in, eep_valid_in;
    logic [1:0]  eep_kind_out, eep_speed_out;
    logic [6:0]  eep_dev_addr_out;
    logic [15:0] eep_offset_out;
    logic        upd_apply_req_out, upd_apply_done_in, otp_cfg_req_out;
    logic [3:0]  otp_cfg_num_out, cfg_num_out;
    logic        otp_cfg_done_in, otp_cfg_found_in, otp_cfg_crc_ok_in;
    logic        otp_fbdiv_set_in, otp_ser_i2c_in, hotfix_present_in;
    logic        hotfix_req_out, hotfix_done_in, image_apply_req_out;
    logic        image_apply_done_in, serial_en_out, serial_i2c_out;
    logic        spi_4wire_out, clk_out_en_out, gpio_oe_n_out;
    logic        monitors_en_out, alarms_en_out, seq_done_out;
    logic        cfg_loaded_out, err_otp_missing_out, err_otp_crc_out;
    logic        err_no_eeprom_out, err_eep_cfg_out;
    logic        slow, fit, upd, cfg, saw_eep, saw_hot, saw_lck, saw_upd;
    logic        saw_rst, saw_bg;
    int          bad_count, cmp_count;
    wire  [7:0]  stat = {cfg_loaded_out, err_otp_missing_out,
        err_otp_crc_out, err_no_eeprom_out, err_eep_cfg_out,
        serial_i2c_out, spi_4wire_out, clk_out_en_out};
    wire  [5:0]  saw = {saw_bg, saw_eep, saw_hot, saw_lck, saw_upd, saw_rst};

    assign {image_apply_done_in, hotfix_done_in, otp_cfg_done_in,
        upd_apply_done_in, eep_done_in, image_done_in, pll_lock_in,
        info_done_in} = done;

    rcs_sequencer rcs_sequencer_i (.*);

    rcs_engine_model rcs_engine_model_i (
        .sys_clk_in, .rst_n_in, .slow_in(slow), .fit_in(fit),
        .upd_in(upd), .cfg_in(cfg), .done_out(done),
        .req_in({image_apply_req_out, hotfix_req_out, otp_cfg_req_out,
            upd_apply_req_out, eep_req_out, image_init_req_out,
            pll_cal_req_out, info_req_out}),
        .kind_in(eep_kind_out), .addr_in(eep_dev_addr_out),
        .speed_in(eep_speed_out), .offset_in(eep_offset_out),
        .ack_out(eep_ack_in), .valid_out(eep_valid_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Sticky record of which engines were called; relock follows hotfix
    always @(posedge sys_clk_in) begin
        if (!master_reset_n_in) begin
            {saw_bg, saw_eep, saw_hot, saw_lck, saw_upd, saw_rst} <= 6'h00;
        end else begin
            if (eep_req_out) saw_eep <= 1'b1;
            if (hotfix_req_out) saw_hot <= 1'b1;
            if (pll_cal_req_out && saw_hot) saw_lck <= 1'b1;
            if (upd_apply_req_out) saw_upd <= 1'b1;
            if (info_req_out && saw_upd) saw_rst <= 1'b1;
            if (pll_bg_cal_out) saw_bg <= 1'b1;
        end
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Pulse the master reset pin, straps set up around the rising edge
    task boot(input logic [7:0] straps, input logic tst);
        master_reset_n_in = 1'b0;
        tick(16);
        gpio_in = straps;
        test_mode_n_in = tst;
        tick(2);
        master_reset_n_in = 1'b1;
        tick(1);
        gpio_in = ~straps;
    endtask

    task wait_done;
        int i;
        for (i = 0; i < 2000 && seq_done_out !== 1'b1; i++) tick(1);
        if (seq_done_out !== 1'b1) begin
            bad_count++;
            $display("MISMATCH seq_done expected 1 seen %b", seq_done_out);
            final_report;
        end
    endtask

    initial begin
        rst_n_in = 1'b0;
        master_reset_n_in = 1'b0;
        test_mode_n_in = 1'b1;
        gpio_in = 8'h00;
        {slow, fit, upd, cfg} = 4'h0;
        {otp_cfg_found_in, otp_cfg_crc_ok_in, otp_fbdiv_set_in} = 3'h7;
        otp_ser_i2c_in = 1'b0;
        hotfix_present_in = 1'b1;
        bad_count = 0;
        cmp_count = 0;
        tick(3);
        rst_n_in = 1'b1;
        tick(1);
        chk("info_req", 8'h01, {7'h00, info_req_out});
        boot(8'h05, 1'b0);
        tick(12);
        chk("image_req", 8'h00, {7'h00, image_init_req_out});
        slow = 1'b1;
        boot(8'h05, 1'b1);
        wait_done;
        chk("status", 8'h83, stat);
        chk("seen", 8'h2c, {2'h0, saw});
        chk("cfg_num", 8'h05, {4'h0, cfg_num_out});
        chk("pins", 8'h01, {5'h00, pll_bg_cal_out, gpio_oe_n_out,
            alarms_en_out});
        master_reset_n_in = 1'b0;
        tick(6);
        chk("reset_pins", 8'h02, {4'h0, serial_en_out, clk_out_en_out,
            gpio_oe_n_out, alarms_en_out});
        boot(8'h05, 1'b1);
        tick(8);
        // Mid-run abort, then EEPROM update, restart and config search
        slow = 1'b0;
        {fit, upd, cfg} = 3'h7;
        otp_cfg_found_in = 1'b0;
        hotfix_present_in = 1'b0;
        boot(8'h33, 1'b1);
        wait_done;
        chk("status", 8'hc5, stat);
        chk("seen", 8'h13, {2'h0, saw});
        fit = 1'b0;
        {otp_cfg_found_in, otp_cfg_crc_ok_in} = 2'h2;
        boot(8'h39, 1'b1);
        wait_done;
        chk("status", 8'h35, stat);
        chk("otp_num", 8'h09, {4'h0, otp_cfg_num_out});
        final_report;
    end
endmodule

bind rcs_sequencer rcs_seq_monitor rcs_seq_monitor_i (.*);
